// ===== design/ccl_consts.svh
// Constants for the comparator channel control block.
`ifndef CCL_CONSTS_SVH
`define CCL_CONSTS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CCL_CTRL0_ADDR 12'h000
`define CCL_CTRL1_ADDR 12'h004
`define CCL_CTRL2_ADDR 12'h008
`define CCL_SUMMARY_ADDR 12'h00c
`define CCL_VREF_ADDR 12'h010
`define CCL_IRQ_STATUS_ADDR 12'h014
`define CCL_IRQ_MASK_ADDR 12'h018

// ****************************************************************
// Control, reference and summary register fields
// ****************************************************************
`define CCL_SEL_LSB 0
`define CCL_NINV_BIT 4
`define CCL_EDGE_LSB 6
`define CCL_RESULT_BIT 8
`define CCL_EVENT_BIT 9
`define CCL_INVERT_BIT 13
`define CCL_OUTEN_BIT 14
`define CCL_ENABLE_BIT 15
`define CCL_CTRL_WMASK 16'he0d3
`define CCL_CTRL_RESET 16'h0000
`define CCL_VREF_LEVEL_LSB 8
`define CCL_VREF_WMASK 16'h07ff
`define CCL_VREF_RESET 16'h0000
`define CCL_SUM_EVT_LSB 8

`endif

// ===== design/ccl_pkg.sv
// Types shared by the comparator channel control block.
package ccl_pkg;
    typedef enum logic [1:0] {
        CCL_EDGE_OFF,
        CCL_EDGE_A,
        CCL_EDGE_B,
        CCL_EDGE_BOTH
    } ccl_edge_type;

    typedef enum logic [1:0] {
        CCL_INV_PIN_B,
        CCL_INV_PIN_C,
        CCL_INV_PIN_D,
        CCL_INV_REF
    } ccl_inv_sel_type;
endpackage

// ===== design/ccl_channel.sv
// One comparator channel: input routing, polarity and event latch.
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.svh"
module ccl_channel (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Configuration from the control register.
    input wire logic outputInvert,
    input wire logic noninvSourceSelect,
    input wire logic [1:0] invertingInputSelect,
    input wire logic [1:0] edgeSelect,
    input wire logic eventClear,
    // Raw comparison from the analog core.
    input wire logic rawCompare,
    // Analog switch controls.
    output logic selNoninvRef,
    output logic [1:0] selInverting,
    // Status.
    output logic resultBit,
    output logic eventFlag,
    output logic eventPulse
);
    logic result_q;
    logic event_q;
    logic adjusted;
    logic rising;
    logic falling;
    logic hit;

    // Switch controls pass straight to the analog multiplexers.
    assign selNoninvRef = noninvSourceSelect;
    assign selInverting = invertingInputSelect;
    // The raw result is high when the noninverting input is higher.
    assign adjusted = rawCompare ^ outputInvert;

    // Registered result so the readback is glitch free.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_q <= 1'b0;
        end else begin
            result_q <= adjusted;
        end
    end

    assign rising = adjusted & ~result_q;
    assign falling = ~adjusted & result_q;

    // Edge codes name raw-sense edges, so inversion swaps direction.
    always_comb begin
        case (ccl_pkg::ccl_edge_type'(edgeSelect))
            ccl_pkg::CCL_EDGE_OFF: hit = 1'b0;
            ccl_pkg::CCL_EDGE_A: hit = outputInvert ? rising : falling;
            ccl_pkg::CCL_EDGE_B: hit = outputInvert ? falling : rising;
            ccl_pkg::CCL_EDGE_BOTH: hit = rising | falling;
            default: hit = 1'b0;
        endcase
    end

    // Flag is sticky and blocks further events; a clear wins over a new edge while the flag is set.
    assign eventPulse = hit & ~event_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_q <= 1'b0;
        end else if (eventPulse) begin
            event_q <= 1'b1;
        end else if (eventClear) begin
            event_q <= 1'b0;
        end
    end

    assign resultBit = result_q;
    assign eventFlag = event_q;
endmodule // ccl_channel
`default_nettype wire

// ===== design/ccl_top.sv
// Three comparator channels with their APB register file.
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.svh"
module ccl_top #(
    parameter int NCH = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core.
    input wire logic [NCH-1:0] rawCompare,
    output logic [NCH-1:0] selNoninvRef,
    output logic [2*NCH-1:0] selInverting,
    output logic [1:0] referenceLevelSelect,
    // Control bits and the registered result passed to the analog and pin logic.
    output logic [NCH-1:0] compEnable,
    output logic [NCH-1:0] compOutEnable,
    output logic [NCH-1:0] compOut,
    // Interrupt.
    output logic irq
);
    logic [15:0] ctrl_q [NCH];
    logic [15:0] vref_q;
    logic [NCH-1:0] irqStatus_q;
    logic [NCH-1:0] irqMask_q;
    logic [NCH-1:0] resultBit;
    logic [NCH-1:0] eventFlag;
    logic [NCH-1:0] eventPulse;
    logic [NCH-1:0] eventClear;
    logic [NCH-1:0] w1c;
    logic wrEn;
    logic rdEn;
    logic mapped;
    logic [31:0] rdData;

    // Single-cycle access phase: no wait states.
    assign pready = 1'b1;
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    assign w1c = pwdata[NCH-1:0];

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        // Writing a one to the flag position of the control word clears it.
        assign eventClear[i] = wrEn && paddr == 12'(4 * i)
            && pwdata[`CCL_EVENT_BIT];
        ccl_channel u_ch (
            .clk(clk),
            .resetn(resetn),
            .outputInvert(ctrl_q[i][`CCL_INVERT_BIT]),
            .noninvSourceSelect(ctrl_q[i][`CCL_NINV_BIT]),
            .invertingInputSelect(ctrl_q[i][`CCL_SEL_LSB +: 2]),
            .edgeSelect(ctrl_q[i][`CCL_EDGE_LSB +: 2]),
            .eventClear(eventClear[i]),
            .rawCompare(rawCompare[i]),
            .selNoninvRef(selNoninvRef[i]),
            .selInverting(selInverting[2*i +: 2]),
            .resultBit(resultBit[i]),
            .eventFlag(eventFlag[i]),
            .eventPulse(eventPulse[i])
        );
        assign compEnable[i] = ctrl_q[i][`CCL_ENABLE_BIT];
        assign compOutEnable[i] = ctrl_q[i][`CCL_OUTEN_BIT];
        assign compOut[i] = resultBit[i];

        // Writable bits only; unimplemented and status bits stay zero.
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                ctrl_q[i] <= `CCL_CTRL_RESET;
            end else if (wrEn && paddr == 12'(4 * i)) begin
                ctrl_q[i] <= pwdata[15:0] & `CCL_CTRL_WMASK;
            end
        end
    end

    // Reference control; only the level field is used here.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vref_q <= `CCL_VREF_RESET;
        end else if (wrEn && paddr == `CCL_VREF_ADDR) begin
            vref_q <= pwdata[15:0] & `CCL_VREF_WMASK;
        end
    end
    assign referenceLevelSelect = vref_q[`CCL_VREF_LEVEL_LSB +: 2];

    // Sticky interrupt status; a new event wins over a write-one clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStatus_q <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (eventPulse[i]) begin
                    irqStatus_q[i] <= 1'b1;
                end else if (wrEn && paddr == `CCL_IRQ_STATUS_ADDR
                    && w1c[i]) begin
                    irqStatus_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqMask_q <= '0;
        end else if (wrEn && paddr == `CCL_IRQ_MASK_ADDR) begin
            irqMask_q <= pwdata[NCH-1:0];
        end
    end
    assign irq = |(irqStatus_q & irqMask_q);

    // Read mux; control words merge live result and event bits.
    always_comb begin
        rdData = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `CCL_SUMMARY_ADDR: begin
                rdData[NCH-1:0] = resultBit;
                rdData[`CCL_SUM_EVT_LSB +: NCH] = eventFlag;
            end
            `CCL_VREF_ADDR: rdData[15:0] = vref_q;
            `CCL_IRQ_STATUS_ADDR: rdData[NCH-1:0] = irqStatus_q;
            `CCL_IRQ_MASK_ADDR: rdData[NCH-1:0] = irqMask_q;
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < NCH; i++) begin
                    if (paddr == 12'(4 * i)) begin
                        mapped = 1'b1;
                        rdData[15:0] = ctrl_q[i];
                        rdData[`CCL_RESULT_BIT] = resultBit[i];
                        rdData[`CCL_EVENT_BIT] = eventFlag[i];
                    end
                end
            end
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    // Read data registered at the access edge would lag; drive directly.
    assign prdata = rdEn ? rdData : 32'h0000_0000;
endmodule // ccl_top
`default_nettype wire

// ===== bench/ccl_top_checker.sv
// Port assertions for the comparator channel control block.
`timescale 1ns/1ps
`default_nettype none
module ccl_top_checker #(
    parameter int NCH = 3
) (
    // Clock, reset, bus and interrupt.
    input wire logic clk, resetn, psel, penable, pwrite, irq,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Analog side.
    input wire logic [NCH-1:0] rawCompare, selNoninvRef, compOut,
    input wire logic [2*NCH-1:0] selInverting,
    input wire logic [1:0] referenceLevelSelect
);
    // Transfers finish in their first access cycle, so decode that cycle.
    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;
    wire logic wrMask = wr && paddr == 12'h018;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    noninv_route_a: assert property (
        wr && paddr == 12'h000 |=> selNoninvRef[0] == $past(pwdata[4]))
        else $error("noninverting source wrong");
    inv_select_a: assert property (
        wr && paddr == 12'h004 |=> selInverting[3:2] == $past(pwdata[1:0]))
        else $error("inverting select wrong");
    ref_level_a: assert property (
        wr && paddr == 12'h010 |=> referenceLevelSelect == $past(pwdata[9:8]))
        else $error("reference level wrong");
    result_polarity_a: assert property (
        wr && paddr == 12'h000 |-> ##2
        compOut[0] == ($past(rawCompare[0]) ^ $past(pwdata[13], 2)))
        else $error("result polarity wrong");
    reserved_zero_a: assert property (
        rd && paddr == 12'h000 |-> !prdata[5] && prdata[3:2] == 2'h0
        && prdata[12:10] == 3'h0)
        else $error("reserved bits not zero");
    ctrl_result_a: assert property (
        rd && paddr == 12'h004 |-> prdata[8] == compOut[1])
        else $error("result bit differs");
    summary_mirror_a: assert property (
        rd && paddr == 12'h00c |-> prdata[NCH-1:0] == compOut)
        else $error("summary differs");
    irq_cause_a: assert property (
        $rose(irq) |-> $changed(compOut) || $past(wrMask))
        else $error("interrupt without event");
endmodule // ccl_top_checker
bind ccl_top ccl_top_checker #(.NCH(NCH)) u_chk (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .irq(irq),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .rawCompare(rawCompare), .selNoninvRef(selNoninvRef),
    .compOut(compOut), .selInverting(selInverting),
    .referenceLevelSelect(referenceLevelSelect));
`default_nettype wire

// ===== bench/ccl_top_tb.sv
// Self-checking bench for the comparator channel control block.
`timescale 1ns/1ps
`default_nettype none
`include "ccl_consts.svh"
module ccl_top_tb;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, lfsr = 32'h00015f42;
    logic pready, pslverr, irq;
    logic [2:0] raw = '0, selNoninv, compOut, compEn, compOe;
    logic [2:0] res, evt, ist, msk;
    logic [5:0] selInv;
    logic [1:0] refLevel;
    logic [15:0] vref;
    logic [15:0] ctl [3];
    int nMismatch = 0, checked = 0, cyc = 0;
    ccl_top u_dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rawCompare(raw), .selNoninvRef(selNoninv), .selInverting(selInv),
        .referenceLevelSelect(refLevel), .compEnable(compEn),
        .compOutEnable(compOe), .compOut(compOut), .irq(irq));
    // Free-running clock.
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register view of the model.
    function automatic logic [31:0] expRd(input logic [11:0] a);
        case (a)
            12'h000, 12'h004, 12'h008: return {16'h0, ctl[a[3:2]] |
                {6'h0, evt[a[3:2]], res[a[3:2]], 8'h0}};
            12'h00c: return {21'h0, evt, 5'h0, res};
            12'h010: return {16'h0, vref};
            12'h014: return {29'h0, ist};
            12'h018: return {29'h0, msk};
            default: return '0;
        endcase
    endfunction
    // Cycle model; it samples the same pre-edge values as the design.
    always @(posedge clk or negedge resetn) begin : model
        logic wr;
        logic [2:0] adj, hit, clr;
        wr = psel && penable && pwrite;
        if (!resetn) begin
            {res, evt, ist, msk, vref} <= '0;
            ctl <= '{default: '0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                adj[i] = raw[i] ^ ctl[i][13];
                hit[i] = adj[i] != res[i] && (ctl[i][7:6] == 2'h3 ||
                    ctl[i][7:6] == {raw[i], !raw[i]});
                clr[i] = wr && paddr == 12'(4 * i) && pwdata[9];
                if (wr && paddr == 12'(4 * i))
                    ctl[i] <= pwdata[15:0] & `CCL_CTRL_WMASK;
            end
            res <= adj;
            evt <= hit & ~evt | evt & ~clr;
            ist <= ist & ~(wr && paddr == 12'h014 ? pwdata[2:0] : 3'h0)
                | hit & ~evt;
            if (wr && paddr == 12'h018)
                msk <= pwdata[2:0];
            if (wr && paddr == 12'h010)
                vref <= pwdata[15:0] & `CCL_VREF_WMASK;
        end
    end
    // Compare every output except prdata and pslverr with the model between edges.
    always @(negedge clk)
        if (resetn)
            chk("outputs", {10'h0, 1'b1, ctl[2][4], ctl[1][4], ctl[0][4],
                ctl[2][1:0], ctl[1][1:0], ctl[0][1:0], vref[9:8], res,
                |(ist & msk), ctl[2][15], ctl[1][15], ctl[0][15], ctl[2][14],
                ctl[1][14], ctl[0][14]}, {10'h0, pready, selNoninv, selInv,
                refLevel,
                compOut, irq, compEn, compOe});
    // One APB transfer, entered just after an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        if (!w)
            chk("prdata", expRd(a), prdata);
        chk("pslverr", {31'h0, a > 12'h018}, {31'h0, pslverr});
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // Random compare results; the bus stays quiet meanwhile.
    task automatic wiggle(input int n);
        repeat (n) begin
            lfsr = nxt(lfsr);
            raw <= lfsr[2:0];
            @(posedge clk);
        end
        @(posedge clk);
    endtask
    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // A hang counts as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            nMismatch++;
            tallyAndFinish();
        end
    end
    // Every edge code with both polarities, random masks and clears.
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        for (int a = 0; a <= 28; a += 4)
            apb(0, 12'(a), '0);
        for (int c = 0; c < 8; c++) begin
            if (c == 4) begin
                resetn <= 0;
                @(posedge clk);
                resetn <= 1;
                @(posedge clk);
            end
            for (int k = 0; k < 3; k++) begin
                lfsr = nxt(lfsr);
                apb(1, 12'(4 * k), {lfsr[31:14], c[2], lfsr[12:10], 1'b1,
                    lfsr[8], c[1:0], lfsr[5:0]});
            end
            wiggle(24);
            for (int a = 0; a < 28; a += 4)
                apb(0, 12'(a), '0);
            lfsr = nxt(lfsr);
            apb(1, 12'h014, lfsr);
            apb(1, 12'h018, nxt(lfsr));
            apb(1, 12'h010, lfsr);
            apb(1, 12'h00c, lfsr);
            wiggle(8);
        end
        tallyAndFinish();
    end
endmodule // ccl_top_tb
`default_nettype wire
